// ---- hdl/sdram_controller_core.sv ----
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sdram_controller_core #(
   parameter int ADDR_W = 28,
   parameter int CAS_LATENCY = 2
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // memory requests
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_seq,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   output logic core_wait_input,
   // interrupt
   output logic irq_refresh_err,
   // memory pins
   output logic mem_clock_enable_out,
   output logic sd_cs_n,
   output logic sd_ras_n,
   output logic sd_cas_n,
   output logic sd_we_n,
   output logic [1:0] sd_ba,
   output logic [12:0] sd_a,
   output logic [3:0] sd_dqm,
   output logic [31:0] sd_dq_out,
   output logic sd_dq_oe_n,
   input wire logic [31:0] sd_dq_in
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_PRE, ST_ACT, ST_RW, ST_RDATA, ST_REF, ST_SREF_IN,
      ST_SREF, ST_SREF_OUT, ST_LPWR, ST_LP_OUT, ST_MODE, ST_WAIT
   } state_e;

   generate
      if (CAS_LATENCY != sdram_ctrl_pkg::CAS_LAT) begin : g_cas
         $error("only a CAS latency of two is served");
      end
      if (ADDR_W < 16 || ADDR_W > 32) begin : g_aw
         $error("ADDR_W must lie between 16 and 32");
      end
   endgenerate

   function automatic logic [3:0] at_least(input logic [3:0] v,
                                           input logic [3:0] lo);
      return (v < lo) ? lo : v;
   endfunction : at_least

   function automatic logic at(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction : at

   // registers
   logic [3:0] mode_reg;
   logic bus_width_select;
   logic [11:0] refresh_count;
   logic [30:0] geom;
   logic lp_en;
   logic irq_mask;
   logic irq_flag;
   logic self_refresh_cmd_bit;
   logic refresh_armed;
   logic ref_pending;
   // sequencer
   state_e state, next_state, ret, next_ret;
   logic [3:0] cmd, next_cmd;
   logic [1:0] next_ba;
   logic [12:0] next_a;
   logic next_cke, next_oe_n, next_ack;
   logic [31:0] next_rdata, next_dq;
   logic row_open;
   logic [12:0] open_row;
   logic [1:0] open_bank;
   logic tm_load, tm_done, wr_load, wr_done, rt_done;
   logic [3:0] tm_val;
   logic ref_issue, open_set, open_clr, self_refresh_cmd_bit_clr;
   logic [31:0] dq_s1, dq_s2;

   // register decode
   wire wr_mode = reg_wr && at(reg_addr, sdram_ctrl_pkg::OFF_MODE);
   wire wr_refr = reg_wr && at(reg_addr, sdram_ctrl_pkg::OFF_REFR);
   wire wr_geom = reg_wr && at(reg_addr, sdram_ctrl_pkg::OFF_GEOM);
   wire wr_self = reg_wr && at(reg_addr, sdram_ctrl_pkg::OFF_SELF);
   wire wr_lpwr = reg_wr && at(reg_addr, sdram_ctrl_pkg::OFF_LPWR);
   wire wr_ier = reg_wr && at(reg_addr, sdram_ctrl_pkg::OFF_IER);
   wire wr_idr = reg_wr && at(reg_addr, sdram_ctrl_pkg::OFF_IDR);
   wire rd_isr = reg_rd && at(reg_addr, sdram_ctrl_pkg::OFF_ISR);
   wire [31:0] rd_mux =
      at(reg_addr, sdram_ctrl_pkg::OFF_MODE) ?
         {27'h0, bus_width_select, mode_reg} :
      at(reg_addr, sdram_ctrl_pkg::OFF_REFR) ? {20'h0, refresh_count} :
      at(reg_addr, sdram_ctrl_pkg::OFF_GEOM) ? {1'b0, geom} :
      at(reg_addr, sdram_ctrl_pkg::OFF_LPWR) ? {31'h0, lp_en} :
      at(reg_addr, sdram_ctrl_pkg::OFF_IMR) ? {31'h0, irq_mask} :
      at(reg_addr, sdram_ctrl_pkg::OFF_ISR) ? {31'h0, irq_flag} :
      32'h0;

   // geometry and timing fields
   wire [1:0] nc = geom[sdram_ctrl_pkg::NC_LSB +: 2];
   wire [1:0] nr = geom[sdram_ctrl_pkg::NR_LSB +: 2];
   wire four_banks = geom[sdram_ctrl_pkg::NB_BIT];
   wire [3:0] write_recovery =
      at_least(geom[sdram_ctrl_pkg::WREC_LSB +: 4], sdram_ctrl_pkg::DELAY_MIN);
   wire [3:0] row_cycle =
      at_least(geom[sdram_ctrl_pkg::RCYC_LSB +: 4], sdram_ctrl_pkg::DELAY_MIN);
   wire [3:0] precharge_delay =
      at_least(geom[sdram_ctrl_pkg::PRE_LSB +: 4], sdram_ctrl_pkg::DELAY_MIN);
   wire [3:0] activate_to_column_delay =
      at_least(geom[sdram_ctrl_pkg::RCD_LSB +: 4], sdram_ctrl_pkg::DELAY_MIN);
   wire [3:0] row_active_min_time =
      at_least(geom[sdram_ctrl_pkg::RAS_LSB +: 4], sdram_ctrl_pkg::DELAY_ONE);
   wire [3:0] self_exit_delay =
      at_least(geom[sdram_ctrl_pkg::XSR_LSB +: 4], sdram_ctrl_pkg::DELAY_ONE);

   // address split; 16-bit bus drops one byte bit, 32-bit drops two
   wire [4:0] col_bits = 5'h08 + {3'h0, nc};
   wire [4:0] row_bits = (nr == 2'h3) ? 5'h0D : 5'h0B + {3'h0, nr};
   wire [ADDR_W-1:0] word =
      bus_width_select ? (mem_addr >> 1) : (mem_addr >> 2);
   wire [ADDR_W-1:0] row_rest = word >> col_bits;
   wire [10:0] dec_col = 11'(word & ~({ADDR_W{1'b1}} << col_bits));
   wire [12:0] dec_row = 13'(row_rest & ~({ADDR_W{1'b1}} << row_bits));
   wire [1:0] dec_bank = 2'(row_rest >> row_bits) & {four_banks, 1'b1};
   // A10 kept low so no auto-precharge rides on the column command
   wire [12:0] col_addr = {1'b0, dec_col[10], 1'b0, dec_col[9:0]};
   wire row_hit = row_open && open_row == dec_row && open_bank == dec_bank;
   // the ack flop blocks a second take while the master drops its request
   wire req_ok = mem_req && !mem_ack;
   wire [31:0] rd_word =
      bus_width_select ? {16'h0, dq_s2[15:0]} : dq_s2;

   // refresh timer
   wire ref_tick = refresh_armed && rt_done && !wr_refr;
   wire ref_done = ref_issue || state == ST_SREF;
   wire ref_err = ref_tick && ref_pending && !ref_done;
   wire rt_load = wr_refr || ref_tick;
   wire [11:0] rt_val = wr_refr ? reg_wdata[11:0] - 12'h001 :
                                  refresh_count - 12'h001;

   count_down_timer #(.W(4)) u_cmd_timer (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .load(tm_load),
      .value(tm_val),
      .done(tm_done)
   );

   count_down_timer #(.W(4)) u_wr_timer (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .load(wr_load),
      .value(write_recovery - sdram_ctrl_pkg::DELAY_ONE),
      .done(wr_done)
   );

   count_down_timer #(.W(12)) u_ref_timer (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .load(rt_load),
      .value(rt_val),
      .done(rt_done)
   );

   always_comb begin
      next_state = state;
      next_ret = ret;
      next_cmd = sdram_ctrl_pkg::CMD_NOP;
      next_ba = sd_ba;
      next_a = sd_a;
      next_cke = 1'b1;
      next_oe_n = 1'b1;
      next_ack = 1'b0;
      next_rdata = mem_rdata;
      next_dq = sd_dq_out;
      tm_load = 1'b0;
      tm_val = 4'h0;
      wr_load = 1'b0;
      ref_issue = 1'b0;
      open_set = 1'b0;
      open_clr = 1'b0;
      self_refresh_cmd_bit_clr = 1'b0;
      case (state)
         ST_IDLE: begin
            if (ref_pending) begin
               next_state = row_open ? ST_PRE : ST_REF;
            end else if (self_refresh_cmd_bit) begin
               next_state = row_open ? ST_PRE : ST_SREF_IN;
            end else if (req_ok && mode_reg != sdram_ctrl_pkg::MODE_NORMAL) begin
               next_state = ST_MODE;
            end else if (req_ok && row_hit && mem_seq) begin
               next_state = ST_RW;
            end else if (req_ok) begin
               next_state = row_open ? ST_PRE : ST_ACT;
            end else if (lp_en) begin
               next_state = ST_LPWR;
            end
         end
         ST_PRE: begin
            if (wr_done) begin
               next_cmd = sdram_ctrl_pkg::CMD_PRE;
               next_a = sdram_ctrl_pkg::ADDR_ALL_BANKS;
               open_clr = 1'b1;
               tm_load = 1'b1;
               tm_val = precharge_delay - sdram_ctrl_pkg::DELAY_ONE;
               next_state = ST_WAIT;
               next_ret = ST_IDLE;
            end
         end
         ST_ACT: begin
            next_cmd = sdram_ctrl_pkg::CMD_ACT;
            next_ba = dec_bank;
            next_a = dec_row;
            open_set = 1'b1;
            tm_load = 1'b1;
            tm_val = activate_to_column_delay - sdram_ctrl_pkg::DELAY_ONE;
            next_state = ST_WAIT;
            next_ret = ST_RW;
         end
         ST_RW: begin
            next_ba = dec_bank;
            next_a = col_addr;
            if (mem_we) begin
               next_cmd = sdram_ctrl_pkg::CMD_WR;
               next_oe_n = 1'b0;
               next_dq = mem_wdata;
               next_ack = 1'b1;
               wr_load = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_cmd = sdram_ctrl_pkg::CMD_RD;
               tm_load = 1'b1;
               tm_val = sdram_ctrl_pkg::RD_WAIT;
               next_state = ST_WAIT;
               next_ret = ST_RDATA;
            end
         end
         ST_RDATA: begin
            next_ack = 1'b1;
            next_rdata = rd_word;
            next_state = ST_IDLE;
         end
         ST_REF: begin
            next_cmd = sdram_ctrl_pkg::CMD_REF;
            ref_issue = 1'b1;
            tm_load = 1'b1;
            tm_val = row_cycle - sdram_ctrl_pkg::DELAY_ONE;
            next_state = ST_WAIT;
            next_ret = ST_IDLE;
         end
         ST_SREF_IN: begin
            next_cmd = sdram_ctrl_pkg::CMD_REF;
            next_cke = 1'b0;
            ref_issue = 1'b1;
            tm_load = 1'b1;
            tm_val = row_active_min_time - sdram_ctrl_pkg::DELAY_ONE;
            next_state = ST_SREF;
         end
         ST_SREF: begin
            next_cke = 1'b0;
            if (tm_done && req_ok) begin
               next_state = ST_SREF_OUT;
            end
         end
         ST_SREF_OUT: begin
            self_refresh_cmd_bit_clr = 1'b1;
            tm_load = 1'b1;
            tm_val = self_exit_delay - sdram_ctrl_pkg::DELAY_ONE;
            next_state = ST_WAIT;
            next_ret = ST_IDLE;
         end
         ST_LPWR: begin
            next_cke = 1'b0;
            if (req_ok || ref_pending || self_refresh_cmd_bit || !lp_en) begin
               next_state = ST_LP_OUT;
            end
         end
         ST_LP_OUT: begin
            next_state = ST_IDLE;
         end
         ST_MODE: begin
            case (mode_reg)
               sdram_ctrl_pkg::MODE_PRECHARGE: begin
                  next_cmd = sdram_ctrl_pkg::CMD_PRE;
                  next_a = sdram_ctrl_pkg::ADDR_ALL_BANKS;
                  open_clr = 1'b1;
               end
               sdram_ctrl_pkg::MODE_LOAD_MODE: begin
                  next_cmd = sdram_ctrl_pkg::CMD_LMR;
                  next_ba = 2'h0;
                  next_a = word[12:0];
               end
               sdram_ctrl_pkg::MODE_REFRESH: begin
                  next_cmd = sdram_ctrl_pkg::CMD_REF;
                  ref_issue = 1'b1;
               end
               default: begin
                  next_cmd = sdram_ctrl_pkg::CMD_NOP;
               end
            endcase
            next_ack = 1'b1;
            next_rdata = 32'h0;
            tm_load = 1'b1;
            tm_val = row_cycle - sdram_ctrl_pkg::DELAY_ONE;
            next_state = ST_WAIT;
            next_ret = ST_IDLE;
         end
         ST_WAIT: begin
            if (tm_done) begin
               next_state = ret;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // register file
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= sdram_ctrl_pkg::MODE_RST;
         bus_width_select <= sdram_ctrl_pkg::BUS_WIDTH_RST;
         refresh_count <= sdram_ctrl_pkg::REFR_RST;
         geom <= sdram_ctrl_pkg::GEOM_RST;
         lp_en <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_reg <= reg_wdata[3:0];
            bus_width_select <= reg_wdata[sdram_ctrl_pkg::MODE_WIDTH_BIT];
         end
         if (wr_refr) begin
            refresh_count <= reg_wdata[11:0];
         end
         if (wr_geom) begin
            geom <= reg_wdata[30:0];
         end
         if (wr_lpwr) begin
            lp_en <= reg_wdata[0];
         end
      end
   end

   // flags: a set in the same cycle as its clear wins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         refresh_armed <= 1'b0;
         ref_pending <= 1'b0;
         irq_mask <= 1'b0;
         irq_flag <= 1'b0;
         self_refresh_cmd_bit <= 1'b0;
      end else begin
         refresh_armed <= refresh_armed || wr_refr;
         ref_pending <= ref_tick || (ref_pending && !ref_done);
         irq_mask <= (wr_ier && reg_wdata[0]) ||
                     (irq_mask && !(wr_idr && reg_wdata[0]));
         irq_flag <= ref_err || (irq_flag && !rd_isr);
         self_refresh_cmd_bit <= (wr_self && reg_wdata[0]) ||
                                 (self_refresh_cmd_bit && !self_refresh_cmd_bit_clr);
      end
   end

   // open row tracking
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         row_open <= 1'b0;
         open_row <= 13'h0000;
         open_bank <= 2'h0;
      end else if (open_set) begin
         row_open <= 1'b1;
         open_row <= dec_row;
         open_bank <= dec_bank;
      end else if (open_clr) begin
         row_open <= 1'b0;
      end
   end

   // sequencer and pins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         ret <= ST_IDLE;
         cmd <= sdram_ctrl_pkg::CMD_NOP;
         sd_ba <= 2'h0;
         sd_a <= 13'h0000;
         mem_clock_enable_out <= 1'b1;
         sd_dq_oe_n <= 1'b1;
         sd_dq_out <= 32'h0;
         sd_dqm <= 4'h0;
      end else begin
         state <= next_state;
         ret <= next_ret;
         cmd <= next_cmd;
         sd_ba <= next_ba;
         sd_a <= next_a;
         mem_clock_enable_out <= next_cke;
         sd_dq_oe_n <= next_oe_n;
         sd_dq_out <= next_dq;
         sd_dqm <= {bus_width_select, bus_width_select, 2'h0};
      end
   end

   // master side answers and register read data
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         core_wait_input <= 1'b0;
         irq_refresh_err <= 1'b0;
         reg_rdata <= 32'h0;
      end else begin
         mem_ack <= next_ack;
         mem_rdata <= next_rdata;
         core_wait_input <= mem_req && !mem_ack && !next_ack;
         irq_refresh_err <= irq_flag && irq_mask;
         reg_rdata <= reg_rd ? rd_mux : 32'h0;
      end
   end

   // read data pins cross in through two stages; only the second is read
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dq_s1 <= 32'h0;
         dq_s2 <= 32'h0;
      end else begin
         dq_s1 <= sd_dq_in;
         dq_s2 <= dq_s1;
      end
   end

   assign sd_cs_n = cmd[3];
   assign sd_ras_n = cmd[2];
   assign sd_cas_n = cmd[1];
   assign sd_we_n = cmd[0];
endmodule : sdram_controller_core
`default_nettype wire

// ---- hdl/sdram_ctrl_pkg.sv ----
`default_nettype none
package sdram_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_REFR = 8'h04;
   localparam logic [7:0] OFF_GEOM = 8'h08;
   localparam logic [7:0] OFF_SELF = 8'h0C;
   localparam logic [7:0] OFF_LPWR = 8'h10;
   localparam logic [7:0] OFF_IER = 8'h14;
   localparam logic [7:0] OFF_IDR = 8'h18;
   localparam logic [7:0] OFF_IMR = 8'h1C;
   localparam logic [7:0] OFF_ISR = 8'h20;
   // reset values
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic BUS_WIDTH_RST = 1'b1;
   localparam logic [11:0] REFR_RST = 12'h800;
   localparam logic [30:0] GEOM_RST = 31'h2A99C140;
   // field positions
   localparam int MODE_WIDTH_BIT = 4;
   localparam int NC_LSB = 0;
   localparam int NR_LSB = 2;
   localparam int NB_BIT = 4;
   localparam int WREC_LSB = 7;
   localparam int RCYC_LSB = 11;
   localparam int PRE_LSB = 15;
   localparam int RCD_LSB = 19;
   localparam int RAS_LSB = 23;
   localparam int XSR_LSB = 27;
   // command mode codes
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_NOP = 4'h1;
   localparam logic [3:0] MODE_PRECHARGE = 4'h2;
   localparam logic [3:0] MODE_LOAD_MODE = 4'h3;
   localparam logic [3:0] MODE_REFRESH = 4'h4;
   // {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_LMR = 4'h0;
   localparam logic [12:0] ADDR_ALL_BANKS = 13'h0400;
   // timing
   localparam int CAS_LAT = 2;
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] RD_WAIT = 4'(CAS_LAT + SYNC_STAGES - 1);
   localparam logic [3:0] DELAY_MIN = 4'h2;
   localparam logic [3:0] DELAY_ONE = 4'h1;
endpackage : sdram_ctrl_pkg
`default_nettype wire

// ---- hdl/count_down_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module count_down_timer #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // control
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   logic [W-1:0] cnt;

   generate
      if (W < 1) begin : g_bad
         $error("count_down_timer width must be positive");
      end
   endgenerate

   assign done = (cnt == '0);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= value;
      end else if (!done) begin
         cnt <= cnt - W'(1);
      end
   end
endmodule : count_down_timer
`default_nettype wire

// ---- tb/sdram_device_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdram_device_model (
   // clock
   input wire logic clk_sys,
   // controller pins
   input wire logic [3:0] cmd,
   input wire logic [1:0] sd_ba,
   input wire logic [12:0] sd_a,
   input wire logic [31:0] sd_dq_out,
   input wire logic sd_dq_oe_n,
   // data back
   output logic [31:0] sd_dq_in
);
   logic [31:0] cells [32];
   logic [31:0] stage;
   logic hit = 1'b0;
   wire logic [4:0] col = {sd_ba[0], sd_a[3:0]};
   initial sd_dq_in = 32'h0;
   // rows fold onto columns; the bench folds its copy the same way
   always @(posedge clk_sys) begin
      if (cmd == sdram_ctrl_pkg::CMD_WR && !sd_dq_oe_n)
         cells[col] <= sd_dq_out;
      hit <= cmd == sdram_ctrl_pkg::CMD_RD;
      stage <= cells[col];
      // released bus toggles so a stale word never passes for data
      sd_dq_in <= hit ? stage : ~sd_dq_in;
   end
endmodule : sdram_device_model
`default_nettype wire

// ---- tb/sdram_controller_core_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdram_controller_core_checker (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // host side
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic mem_ack,
   // memory pins
   input wire logic mem_clock_enable_out,
   input wire logic sd_cs_n,
   input wire logic sd_ras_n,
   input wire logic sd_cas_n,
   input wire logic sd_we_n,
   input wire logic [12:0] sd_a,
   input wire logic sd_dq_oe_n
);
   wire logic [3:0] cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
   wire logic cke = mem_clock_enable_out;
   wire logic is_pre = cmd == sdram_ctrl_pkg::CMD_PRE;
   wire logic is_act = cmd == sdram_ctrl_pkg::CMD_ACT;
   wire logic is_rd = cmd == sdram_ctrl_pkg::CMD_RD;
   wire logic is_wr = cmd == sdram_ctrl_pkg::CMD_WR;
   wire logic is_ref = cmd == sdram_ctrl_pkg::CMD_REF;
   // mode and self-refresh writes may also lead to a refresh command
   wire logic arm = reg_wr && reg_addr inside {sdram_ctrl_pkg::OFF_MODE,
      sdram_ctrl_pkg::OFF_REFR, sdram_ctrl_pkg::OFF_SELF};
   logic armed;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) armed <= 1'b0;
      else if (arm) armed <= 1'b1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_pre; is_pre; endsequence
   sequence s_act; is_act; endsequence
   sequence s_sleep; is_ref && !cke ##1 !cke; endsequence
   property p_drive; !sd_dq_oe_n |-> is_wr; endproperty
   property p_pre_gap; s_pre |=> !is_act; endproperty
   property p_act_gap; s_act |=> !(is_rd || is_wr); endproperty
   property p_rd_ack; is_rd |-> ##[1:8] mem_ack; endproperty
   property p_pre_all; s_pre |-> sd_a[10]; endproperty
   property p_sleep; s_sleep |-> !cke [*3]; endproperty
   property p_wake; $rose(cke) |-> cmd == sdram_ctrl_pkg::CMD_NOP; endproperty
   property p_armed; is_ref |-> armed; endproperty
   a_drive: assert property (p_drive) else $error("dq driven");
   a_pre_gap: assert property (p_pre_gap) else $error("pre gap");
   a_act_gap: assert property (p_act_gap) else $error("act gap");
   a_rd_ack: assert property (p_rd_ack) else $error("read ack");
   a_pre_all: assert property (p_pre_all) else $error("pre all");
   a_sleep: assert property (p_sleep) else $error("sleep short");
   a_wake: assert property (p_wake) else $error("wake cmd");
   a_armed: assert property (p_armed) else $error("early ref");
endmodule : sdram_controller_core_checker
bind sdram_controller_core sdram_controller_core_checker i_checker (.*);
`default_nettype wire

// ---- tb/sdram_controller_core_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdram_controller_core_test;
   logic clk_sys, resetn, reg_wr, reg_rd, mem_req, mem_we, mem_seq;
   logic mem_ack, core_wait_input, irq_refresh_err, mem_clock_enable_out;
   logic sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe_n;
   logic [7:0] reg_addr;
   logic [27:0] mem_addr;
   logic [31:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata;
   logic [31:0] sd_dq_out, sd_dq_in, got, r;
   logic [1:0] sd_ba;
   logic [12:0] sd_a, last_a;
   logic [3:0] sd_dqm, last_cmd;
   logic [31:0] exp_mem [32];
   int n_fail = 0, checks = 0, seed = 12856;
   int cyc = 0, n_ref = 0, ref_cyc = 0, t;
   wire logic [3:0] cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
   localparam logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h10,
      8'h1C, 8'h20, 8'h0C, 8'h24};
   localparam logic [31:0] rsts [8] = '{32'h10, 32'h800, 32'h2A99C140,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   localparam logic [3:0] mode_cmd [4] = '{sdram_ctrl_pkg::CMD_NOP,
      sdram_ctrl_pkg::CMD_PRE, sdram_ctrl_pkg::CMD_LMR,
      sdram_ctrl_pkg::CMD_REF};
   sdram_controller_core i_sdram_controller_core (.*);
   sdram_device_model i_sdram_device_model (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (!sd_cs_n && cmd != sdram_ctrl_pkg::CMD_NOP) begin
         last_cmd <= cmd;
         last_a <= sd_a;
      end
      if (cmd == sdram_ctrl_pkg::CMD_REF) begin
         n_ref <= n_ref + 1;
         ref_cyc <= cyc;
      end
   end
   function automatic logic [4:0] key(input logic [27:0] a);
      return {a[21], a[5:2]};
   endfunction : key
   task automatic cmp(input string what, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 got = reg_rdata;
   endtask : rd
   // request is held until the ack is seen, dropped on the next edge
   task automatic acc(input logic we, input logic seq, input logic [27:0] a);
      int n;
      logic [31:0] d;
      d = $random(seed);
      n = 0;
      @(posedge clk_sys);
      mem_req <= 1'b1;
      mem_we <= we;
      mem_seq <= seq;
      mem_addr <= a;
      mem_wdata <= d;
      do begin
         @(posedge clk_sys);
         #1 n++;
         if (n == 1) cmp("wait raised", 32'h1, 32'(core_wait_input));
      end while (mem_ack !== 1'b1 && n < 400);
      cmp("ack in time", 32'h1, 32'(n < 400));
      cmp("wait dropped", 32'h0, 32'(core_wait_input));
      if (we) exp_mem[key(a)] = d;
      else cmp("read data", exp_mem[key(a)], mem_rdata);
      @(posedge clk_sys);
      mem_req <= 1'b0;
   endtask : acc
   task automatic wait_ref;
      int k;
      k = n_ref;
      for (int j = 0; j < 5000 && n_ref == k; j++) @(posedge clk_sys);
   endtask : wait_ref
   task automatic final_report;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   initial begin
      {reg_wr, reg_rd, mem_req, mem_we, mem_seq} = 5'h0;
      {reg_addr, reg_wdata, mem_addr, mem_wdata} = '0;
      resetn = 1'b0;
      idle(12);
      resetn <= 1'b1;
      foreach (offs[i]) begin
         rd(offs[i]);
         cmp("reset value", rsts[i], got);
      end
      cmp("dqm 16-bit", 32'hC, 32'(sd_dqm));
      wr(sdram_ctrl_pkg::OFF_MODE, 32'h0);
      // a burst of 16 words crosses the row end at 0x400
      for (int b = 0; b < 2; b++)
         for (int i = 0; i < 16; i++)
            acc(1'b1, i > 0, 28'(b * 32'h200000 + 32'h3F0 + i * 4));
      cmp("dqm 32-bit", 32'h0, 32'(sd_dqm));
      cmp("refresh unarmed", 32'h0, 32'(n_ref));
      wr(sdram_ctrl_pkg::OFF_REFR, 32'd40);
      // the first refresh also closes the open row, so time later ones
      wait_ref();
      wait_ref();
      t = ref_cyc;
      wait_ref();
      cmp("refresh period", 32'd40, 32'(ref_cyc - t));
      $display("test bursts and refresh done");
      repeat (60) begin
         r = $random(seed);
         acc(r[0], r[1], {6'h0, r[21:2], 2'h0});
      end
      for (int i = 0; i < 16; i++)
         acc(1'b0, i > 0, 28'(32'h3F0 + i * 4));
      $display("test traffic done");
      wr(sdram_ctrl_pkg::OFF_IER, 32'h1);
      wr(sdram_ctrl_pkg::OFF_REFR, 32'h1);
      idle(30);
      cmp("irq raised", 32'h1, 32'(irq_refresh_err));
      wr(sdram_ctrl_pkg::OFF_IDR, 32'h1);
      idle(3);
      cmp("irq masked", 32'h0, 32'(irq_refresh_err));
      wr(sdram_ctrl_pkg::OFF_REFR, 32'hFFF);
      idle(30);
      rd(sdram_ctrl_pkg::OFF_ISR);
      cmp("error flag", 32'h1, got);
      rd(sdram_ctrl_pkg::OFF_ISR);
      cmp("flag cleared", 32'h0, got);
      for (int m = 1; m < 5; m++) begin
         wr(sdram_ctrl_pkg::OFF_MODE, 32'(m));
         #1 last_cmd = sdram_ctrl_pkg::CMD_NOP;
         acc(1'b1, 1'b0, 28'h8C);
         // the command log settles just after the edge the task ends on
         #1 cmp("mode command", 32'(mode_cmd[m-1]), 32'(last_cmd));
         if (m == 3) cmp("load value", 32'h23, 32'(last_a));
      end
      wr(sdram_ctrl_pkg::OFF_MODE, 32'h0);
      $display("test error and modes done");
      // the bit is gone after each exit, so it is written every round
      for (int s = 0; s < 2; s++) begin
         wr(sdram_ctrl_pkg::OFF_SELF, 32'h1);
         idle(20);
         cmp("cke asleep", 32'h0, 32'(mem_clock_enable_out));
         acc(1'b0, 1'b0, 28'(32'h3F0 + s * 4));
         cmp("cke awake", 32'h1, 32'(mem_clock_enable_out));
      end
      wr(sdram_ctrl_pkg::OFF_REFR, 32'd40);
      wr(sdram_ctrl_pkg::OFF_LPWR, 32'h1);
      idle(10);
      t = n_ref;
      cmp("cke low power", 32'h0, 32'(mem_clock_enable_out));
      cmp("buffers off", 32'h1, 32'(sd_dq_oe_n));
      idle(200);
      cmp("refresh in low power", 32'h1, 32'(n_ref > t));
      acc(1'b0, 1'b0, 28'h3F8);
      wr(sdram_ctrl_pkg::OFF_LPWR, 32'h0);
      $display("test power modes done");
      final_report();
   end
   initial begin
      #500000;
      n_fail++;
      final_report();
   end
endmodule : sdram_controller_core_test
`default_nettype wire
